/* design/lock_defs.svh */
// command codes, lock map geometry and timing counts for the lock and soft-reset block
`ifndef LOCK_DEFS_SVH
`define LOCK_DEFS_SVH
`define OP_LOCK_ONE      8'h36
`define OP_UNLOCK_ONE    8'h39
`define OP_READ_LOCK     8'h3D
`define OP_LOCK_ALL      8'h7E
`define OP_UNLOCK_ALL    8'h98
`define OP_RESET_ENABLE  8'h66
`define OP_RESET_DEVICE  8'h99
`define OP_WRITE_ENABLE  8'h06
`define OP_PAGE_PROGRAM  8'h02
`define OP_ERASE_4K      8'h20
`define OP_ERASE_32K     8'h52
`define OP_ERASE_64K     8'hD8
`define ADDR_BITS        24
`define NUM_BLOCKS       256
`define NUM_SMALL        16
`define NUM_UNITS        286
`define LOCK_RESET_VAL   1'b1
`define CLK_MHZ          25
`define RESET_TIME_US    30
`define RESET_CYCLES     (`RESET_TIME_US * `CLK_MHZ)
`endif

/* design/lock_pkg.sv */
// types shared by the lock and soft-reset block
package lock_pkg;
  typedef enum logic [1:0] {
    st_opcode,
    st_address,
    st_shift_out,
    st_ignore
  } frame_state_t;
endpackage

/* design/lock_cmd.sv */
// serial command interpreter for per-unit lock bits and two-step soft reset
`timescale 1ns/100ps
`include "lock_defs.svh"
module lock_cmd (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic        sdi_pin,
  input  wire logic        individual_protect_select,
  input  wire logic        protect_complement,
  input  wire logic        small_unit_granularity,
  input  wire logic        top_or_bottom_select,
  input  wire logic [2:0]  block_protect_field,
  input  wire logic        array_busy,
  output logic             sdo,
  output logic             sdo_oe,
  output logic             write_enable_latch,
  output logic             paused_op_flag,
  output logic [7:0]       read_param_bits,
  output logic [2:0]       wrap_setting_bits,
  output logic             reset_busy,
  output logic             write_go,
  output logic [23:0]      write_addr,
  output logic [7:0]       write_op,
  output logic             write_blocked
);
  localparam int RST_CNT = `RESET_CYCLES;

  // unit index: top and bottom 64KB blocks split into 16 sectors each
  function automatic logic [8:0] unit_of(input logic [23:0] a);
    logic [7:0] blk;
    blk = a[23:16];
    if (blk == 8'h00)
      unit_of = {5'h00, a[15:12]};
    else if (blk == 8'hFF)
      unit_of = 9'(`NUM_UNITS - `NUM_SMALL) + {5'h00, a[15:12]};
    else
      unit_of = 9'(`NUM_SMALL - 1) + {1'b0, blk};
  endfunction

  // block-protect scheme: protected range of 64KB blocks or 4KB sectors
  function automatic logic bp_protects(input logic [23:0] a, input logic cmp, input logic sec,
                                       input logic tb, input logic [2:0] bp);
    logic       hit;
    logic [7:0] span;
    hit = 1'b0;
    span = 8'h00;
    if (bp != 3'h0) begin
      if (sec) begin
        span = 8'h01 << ((bp > 3'h4) ? 3'h4 : bp - 3'h1);
        hit = tb ? (a[23:16] == 8'h00 && {4'h0, a[15:12]} < span)
                 : (a[23:16] == 8'hFF && {4'h0, ~a[15:12]} < span);
      end else begin
        span = (bp == 3'h7) ? 8'hFF : (8'h04 << (bp - 3'h1));
        hit = (bp == 3'h7) ? 1'b1 : (tb ? (a[23:16] < span) : (~a[23:16] < span));
      end
    end
    bp_protects = hit ^ cmp;
  endfunction

  logic cs_m, cs_s, sck_m, sck_s, sck_d, sdi_m, sdi_s;
  always_ff @(posedge clk) begin
    cs_m  <= cs_n_pin;
    cs_s  <= cs_m;
    sck_m <= sclk_pin;
    sck_s <= sck_m;
    sdi_m <= sdi_pin;
    sdi_s <= sdi_m;
    sck_d <= sck_s;
  end
  wire rise = sck_s & ~sck_d & ~cs_s;
  wire fall = ~sck_s & sck_d & ~cs_s;

  logic [`NUM_UNITS-1:0]  lock_reg, lock_next;
  lock_pkg::frame_state_t state_reg, state_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic [7:0]  op_reg, op_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0]  out_reg, out_next;
  logic        cs_d_reg, wel_reg, wel_next, rsten_reg, rsten_next, sus_reg, sus_next;
  logic [7:0]  rp_reg, rp_next;
  logic [2:0]  wrap_reg, wrap_next;
  logic [13:0] rst_cnt_reg, rst_cnt_next;
  logic        sdo_reg, sdo_next, oe_reg, oe_next, go_reg, go_next, blk_reg, blk_next;
  logic [7:0]  wop_reg, wop_next;
  logic [23:0] wad_reg, wad_next;
  logic        busy_reg, busy_next;

  wire frame_end = cs_s & ~cs_d_reg;
  wire byte_done = rise && cnt_reg[2:0] == 3'h7;

  always_comb begin
    logic [7:0]  op_full;
    logic [23:0] a_full;
    logic        prot;
    op_full = {op_reg[6:0], sdi_s};
    a_full  = {addr_reg[22:0], sdi_s};
    prot    = 1'b0;
    state_next = state_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    out_next = out_reg;
    lock_next = lock_reg;
    wel_next = wel_reg;
    rsten_next = rsten_reg;
    sus_next = sus_reg;
    rp_next = rp_reg;
    wrap_next = wrap_reg;
    rst_cnt_next = (rst_cnt_reg != 14'h0) ? rst_cnt_reg - 14'h1 : 14'h0;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    go_next = 1'b0;
    blk_next = 1'b0;
    wop_next = wop_reg;
    wad_next = wad_reg;
    if (cs_s) begin
      state_next = lock_pkg::st_opcode;
      cnt_next = 6'h0;
      oe_next = 1'b0;
    end
    if (rst_cnt_reg != 14'h0) begin
      if (!cs_s)
        state_next = lock_pkg::st_ignore;
    end else if (rise) begin
      cnt_next = cnt_reg + 6'h1;
      case (state_reg)
        lock_pkg::st_opcode: begin
          op_next = op_full;
          if (byte_done) begin
            // a reset-enable survives only into a reset opcode, whose frame end then consumes it
            rsten_next = (op_full == `OP_RESET_ENABLE) || (op_full == `OP_RESET_DEVICE && rsten_reg);
            if (op_full == `OP_RESET_DEVICE && !rsten_reg)
              state_next = lock_pkg::st_ignore;
            else if (op_full == `OP_LOCK_ONE || op_full == `OP_UNLOCK_ONE || op_full == `OP_READ_LOCK ||
                     op_full == `OP_PAGE_PROGRAM || op_full == `OP_ERASE_4K ||
                     op_full == `OP_ERASE_32K || op_full == `OP_ERASE_64K)
              state_next = lock_pkg::st_address;
            else
              state_next = lock_pkg::st_ignore;
          end
        end
        lock_pkg::st_address: begin
          addr_next = a_full;
          if (cnt_reg == 6'h1F && op_reg == `OP_READ_LOCK) begin
            out_next = {7'h00, lock_reg[unit_of(a_full)]};
            state_next = lock_pkg::st_shift_out;
          end
        end
        default: ;
      endcase
    end
    // byte recirculates so a long clock train repeats it
    if (state_reg == lock_pkg::st_shift_out && fall && rst_cnt_reg == 14'h0) begin
      sdo_next = out_reg[7];
      oe_next = 1'b1;
      out_next = {out_reg[6:0], out_reg[7]};
    end
    if (frame_end && rst_cnt_reg == 14'h0) begin
      if (cnt_reg == 6'h08 && op_reg == `OP_RESET_DEVICE && rsten_reg) begin
        lock_next = {`NUM_UNITS{`LOCK_RESET_VAL}};
        wel_next = 1'b0;
        sus_next = 1'b0;
        rp_next = 8'h00;
        wrap_next = 3'h0;
        rsten_next = 1'b0;
        rst_cnt_next = 14'(RST_CNT);
      end else if (cnt_reg == 6'h08 && op_reg == `OP_WRITE_ENABLE) begin
        wel_next = 1'b1;
      end else if (cnt_reg == 6'h08 && wel_reg && op_reg == `OP_LOCK_ALL) begin
        lock_next = {`NUM_UNITS{1'b1}};
        wel_next = 1'b0;
      end else if (cnt_reg == 6'h08 && wel_reg && op_reg == `OP_UNLOCK_ALL) begin
        lock_next = {`NUM_UNITS{1'b0}};
        wel_next = 1'b0;
      end else if (cnt_reg == 6'h20 && wel_reg &&
                   (op_reg == `OP_LOCK_ONE || op_reg == `OP_UNLOCK_ONE)) begin
        lock_next[unit_of(addr_reg)] = (op_reg == `OP_LOCK_ONE);
        wel_next = 1'b0;
      end else if (cnt_reg >= 6'h20 && wel_reg && op_reg != `OP_READ_LOCK && op_reg != `OP_LOCK_ONE &&
                   op_reg != `OP_UNLOCK_ONE) begin
        if (individual_protect_select)
          prot = lock_reg[unit_of(addr_reg)];
        else
          prot = bp_protects(addr_reg, protect_complement, small_unit_granularity,
                             top_or_bottom_select, block_protect_field);
        go_next = ~prot;
        blk_next = prot;
        wop_next = op_reg;
        wad_next = addr_reg;
        wel_next = 1'b0;
      end
    end
    busy_next = (rst_cnt_next != 14'h0);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= lock_pkg::st_opcode;
      cnt_reg <= 6'h0;
      op_reg <= 8'h00;
      addr_reg <= 24'h000000;
      out_reg <= 8'h00;
      lock_reg <= {`NUM_UNITS{`LOCK_RESET_VAL}};
      cs_d_reg <= 1'b1;
      wel_reg <= 1'b0;
      rsten_reg <= 1'b0;
      sus_reg <= 1'b0;
      rp_reg <= 8'h00;
      wrap_reg <= 3'h0;
      rst_cnt_reg <= 14'h0;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      go_reg <= 1'b0;
      blk_reg <= 1'b0;
      wop_reg <= 8'h00;
      wad_reg <= 24'h000000;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      out_reg <= out_next;
      lock_reg <= lock_next;
      cs_d_reg <= cs_s;
      wel_reg <= wel_next;
      rsten_reg <= rsten_next;
      sus_reg <= sus_next;
      rp_reg <= rp_next;
      wrap_reg <= wrap_next;
      rst_cnt_reg <= rst_cnt_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      go_reg <= go_next;
      blk_reg <= blk_next;
      wop_reg <= wop_next;
      wad_reg <= wad_next;
      busy_reg <= busy_next;
    end
  end

  assign sdo = sdo_reg;
  assign sdo_oe = oe_reg;
  assign write_enable_latch = wel_reg;
  assign paused_op_flag = sus_reg;
  assign read_param_bits = rp_reg;
  assign wrap_setting_bits = wrap_reg;
  assign reset_busy = busy_reg;
  assign write_go = go_reg;
  assign write_blocked = blk_reg;
  assign write_op = wop_reg;
  assign write_addr = wad_reg;
  // busy of the array engine is neither used nor reported; host must check it before reset
  wire unused_busy = array_busy;
endmodule

/* test/lock_cmd_checker.sv */
// port assertions for the lock and soft-reset block
`timescale 1ns/100ps
module lock_cmd_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic write_enable_latch,
  input wire logic paused_op_flag,
  input wire logic reset_busy,
  input wire logic write_go,
  input wire logic write_blocked
);
  logic [9:0] cnt_reg;
  logic [9:0] cnt_next;
  logic       pulse;
  // busy is far too long for a repetition, so it is counted
  always_comb cnt_next = (reset_busy && !srst) ? cnt_reg + 10'h001 : 10'h000;
  always_ff @(posedge clk) cnt_reg <= cnt_next;
  assign pulse = write_go || write_blocked;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence idle_s; cs_n_pin [*5]; endsequence
  sequence risen_s; $past(cs_n_pin) && $past(cs_n_pin, 2); endsequence
  a_oe_after_deselect: assert property (idle_s |=> !sdo_oe)
    else $error("oe after deselect");
  a_sdo_on_fall: assert property ($changed(sdo) && sdo_oe && $past(sdo_oe) |-> !$past(sclk_pin, 2))
    else $error("sdo moved off fall");
  a_pulse_single: assert property (pulse |-> !(write_go && write_blocked) ##1 !pulse)
    else $error("bad write pulse");
  a_pulse_after_cs: assert property (pulse |-> risen_s)
    else $error("write pulse in frame");
  a_wel_after_cs: assert property ($rose(write_enable_latch) |-> risen_s)
    else $error("latch set in frame");
  a_busy_after_cs: assert property ($rose(reset_busy) |-> risen_s)
    else $error("reset in frame");
  a_busy_length: assert property ($fell(reset_busy) |-> cnt_reg == 10'h2EE)
    else $error("busy length");
  a_busy_clears: assert property (reset_busy |=> !write_enable_latch && !paused_op_flag)
    else $error("state kept in reset");
endmodule

/* test/spi_host_model.sv */
// spi host model: frames commands and gathers the returned lock byte
`timescale 1ns/100ps
module spi_host_model (
  input wire logic clk,
  input wire logic sdo,
  output logic     cs_n_pin,
  output logic     sclk_pin,
  output logic     sdi_pin
);
  logic [7:0] rd_byte = 8'h00;
  logic       rd_done = 1'b0;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin = 1'b0;
  end
  // sclk parks low between frames; 4 clk per half keeps it within the sampler's reach
  task automatic frame(input logic [39:0] bits, input int nbits);
    @(negedge clk) cs_n_pin = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      repeat (4) @(negedge clk);
      sclk_pin = 1'b0;
      sdi_pin = bits[39 - i];
      repeat (4) @(negedge clk);
      sclk_pin = 1'b1;
      rd_byte = {rd_byte[6:0], sdo};
    end
    repeat (4) @(negedge clk);
    sclk_pin = 1'b0;
    repeat (4) @(negedge clk);
    cs_n_pin = 1'b1;
    // released data line must not keep looking valid
    sdi_pin = ~sdi_pin;
    rd_done = (nbits == 40);
    @(negedge clk);
    rd_done = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule

/* test/testbench.sv */
// self-checking bench for the lock and soft-reset block
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        individual_protect_select = 1'b1;
  logic        protect_complement = 1'b0;
  logic        small_unit_granularity = 1'b0;
  logic        top_or_bottom_select = 1'b0;
  logic [2:0]  block_protect_field = 3'h0;
  logic        array_busy = 1'b0;
  wire logic   cs_n_pin, sclk_pin, sdi_pin, sdo, sdo_oe, write_enable_latch, paused_op_flag;
  wire logic   reset_busy, write_go, write_blocked;
  wire logic [7:0]  read_param_bits, write_op;
  wire logic [2:0]  wrap_setting_bits;
  wire logic [23:0] write_addr;
  logic [31:0] exp_q[$];
  logic [7:0]  op_q[$];
  logic [1:0]  er_sel = 2'h0;
  logic [31:0] obs;
  logic [15:0] rnd = 16'h4981;
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #20 clk = ~clk;
  lock_cmd lock_cmd_inst (.clk, .srst, .cs_n_pin, .sclk_pin, .sdi_pin, .individual_protect_select,
    .protect_complement, .small_unit_granularity, .top_or_bottom_select, .block_protect_field, .array_busy,
    .sdo, .sdo_oe, .write_enable_latch, .paused_op_flag, .read_param_bits, .wrap_setting_bits, .reset_busy,
    .write_go, .write_addr, .write_op, .write_blocked);
  spi_host_model spi_host_model_inst (.clk, .sdo, .cs_n_pin, .sclk_pin, .sdi_pin);
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("ERROR %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    check(32'(exp_q.size()), 32'h0);
    check(32'(op_q.size()), 32'h0);
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int n);
    spi_host_model_inst.frame({op, a, rnd[7:0]}, n);
  endtask
  task automatic cmd(input logic [7:0] op);
    send(op, 24'h0, 8);
  endtask
  task automatic rd(input logic [23:0] a, input logic [7:0] want);
    rnd = lfsr(rnd);
    {protect_complement, small_unit_granularity, top_or_bottom_select, block_protect_field, array_busy} = rnd[14:8];
    exp_q.push_back({24'h0, want});
    send(8'h3D, a, 40);
  endtask
  task automatic er(input logic [23:0] a, input logic [1:0] want);
    logic [7:0] op;
    // walk through program and every erase size so each decoded opcode is exercised
    op = (er_sel == 2'h0) ? 8'h02 : (er_sel == 2'h1) ? 8'h20 : (er_sel == 2'h2) ? 8'h52 : 8'hD8;
    er_sel = er_sel + 2'h1;
    cmd(8'h06);
    exp_q.push_back({want, 6'h0, a});
    op_q.push_back(op);
    send(op, a, 32);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      $display("ERROR %0t timeout", $time);
      finish_test();
    end
    if (write_go === 1'b1 || write_blocked === 1'b1 || spi_host_model_inst.rd_done) begin
      obs = spi_host_model_inst.rd_done ? {24'h0, spi_host_model_inst.rd_byte} : {write_go, write_blocked, 6'h0, write_addr};
      check(obs, exp_q.size() > 0 ? exp_q.pop_front() : 32'hX);
      if (!spi_host_model_inst.rd_done)
        check(32'(write_op), op_q.size() > 0 ? 32'(op_q.pop_front()) : 32'hX);
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    // only reads and one unlock sent without write enable precede the first write enable; the supply-ramp wait lies outside this block
    repeat (4) @(negedge clk);
    rd(24'h123456, 8'h01);
    send(8'h39, 24'h123456, 32);
    rd(24'h123456, 8'h01);
    check(32'(write_enable_latch), 32'h0);
    $display("test 1 done");
    cmd(8'h06);
    check(32'(write_enable_latch), 32'h1);
    send(8'h39, 24'h001000, 32);
    rd(24'h001FFF, 8'h00);
    rd(24'h002000, 8'h01);
    cmd(8'h06);
    send(8'h39, 24'h450000, 32);
    rd(24'h45FFFF, 8'h00);
    rd(24'h460000, 8'h01);
    $display("test 2 done");
    er(24'h450123, 2'b10);
    er(24'h460000, 2'b01);
    er(24'h001ABC, 2'b10);
    {individual_protect_select, protect_complement, block_protect_field} = 5'h00;
    er(24'h460000, 2'b10);
    individual_protect_select = 1'b1;
    cmd(8'h06);
    send(8'h36, 24'h450000, 32);
    rd(24'h450000, 8'h01);
    $display("test 3 done");
    cmd(8'h06);
    cmd(8'h98);
    for (int i = 0; i < 4; i++)
      rd({rnd, rnd[15:8]}, 8'h00);
    cmd(8'h06);
    cmd(8'h7E);
    rd({rnd, rnd[7:0]}, 8'h01);
    cmd(8'h06);
    cmd(8'h98);
    $display("test 4 done");
    array_busy = 1'b0;
    cmd(8'h66);
    cmd(8'h06);
    cmd(8'h99);
    check(32'(reset_busy), 32'h0);
    cmd(8'h66);
    cmd(8'h99);
    check(32'(reset_busy), 32'h1);
    check(32'(write_enable_latch), 32'h0);
    check(32'({read_param_bits, wrap_setting_bits, paused_op_flag}), 32'h0);
    cmd(8'h06);
    check(32'(write_enable_latch), 32'h0);
    while (reset_busy === 1'b1)
      @(negedge clk);
    rd(24'h45FFFF, 8'h01);
    $display("test 5 done");
    finish_test();
  end
endmodule
bind lock_cmd lock_cmd_checker lock_cmd_checker_inst (.clk, .srst, .cs_n_pin, .sclk_pin, .sdo, .sdo_oe,
  .write_enable_latch, .paused_op_flag, .reset_busy, .write_go, .write_blocked);
